//--- hw/mfd_microword_decoder.sv
// Microword format decoder with an APB register port.
// Assumes an APB master on pclk; software loads a word and reads the decode.
//
// Summary of operation
// - A 32-bit microword is accepted and one of exactly six kinds is recognised.
// - The kind comes only from the selector field; the ALU, second bus and destination fields are read alike for every kind, the rest by kind.
// - Kinds 1 to 5 with the alternate ALU marker in the ALU field become special kinds.
// - In special kinds 1 to 4 the misc field position carries the alternate operation.
// - Each field value selects at most one micro-operation.
// - Kind 6 yields a literal field plus the ALU, second bus and destination fields.
// - Kinds 3, 4 and 5 put the working total register, number 4, on the first bus.
// - Short targets stay in the 64-word block, except from location 3f into the next.
// - A special kind 5 takes its low four target bits from the macro word register.
// - Kind 6 drives the literal onto the first operand bus.
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
module mfd_microword_decoder #(
	parameter int unsigned WORD_W = 32                 // Microword width.
) (
	input  wire logic        pclk,       // APB clock, 25 MHz.
	input  wire logic        presetn,    // Asynchronous reset, active low.
	input  wire logic        psel,       // APB select.
	input  wire logic        penable,    // APB access phase.
	input  wire logic        pwrite,     // APB write direction.
	input  wire logic [7:0]  paddr,      // APB byte address.
	input  wire logic [31:0] pwdata,     // APB write data.
	input  wire logic [3:0]  pstrb,      // APB byte strobes.
	output logic [31:0]      prdata,     // APB read data.
	output logic             pready,     // APB ready, always high.
	output logic             pslverr,    // APB error on unmapped address.
	output logic [2:0]       dec_kind,   // Registered decoded kind.
	output logic             dec_special,// Registered special flag.
	output logic             dec_lit,    // Registered literal-on-first-bus flag.
	output logic [13:0]      dec_target  // Registered branch target.
);

	if (WORD_W != 32) begin : g_width_check
		$error("mfd_microword_decoder supports only a 32-bit microword");
	end

	logic [31:0]        word_q;
	logic [13:0]        addr_q;
	logic [15:0]        macro_q;
	logic [31:0]        wmask;
	logic               wr_en;
	logic               hit;
	mfd_pkg::mfd_kind_t kind_c;
	logic               special_c, lit_c, tgtv_c;
	logic [4:0]         alt_c, areg_c, misca_c, second_operand_bus_select_c, result_destination_field_c;
	logic [15:0]        litv_c;
	logic [3:0]         mred_c, maux_c, cond_c, alu_c;
	logic [13:0]        tgt_c;
	logic [2:0]         kind_q;
	logic               special_q, lit_q, tgtv_q;
	logic [4:0]         alt_q, areg_q, misca_q, second_operand_bus_select_q, result_destination_field_q;
	logic [15:0]        litv_q;
	logic [3:0]         mred_q, maux_q, cond_q, alu_q;
	logic [13:0]        tgt_q;

	// Byte strobes widen to a bit mask so partial writes keep other lanes.
	for (genvar b = 0; b < 4; b++) begin : g_lane
		assign wmask[8*b +: 8] = {8{pstrb[b]}};
	end

	assign wr_en   = psel && penable && pwrite;
	assign pready  = 1'b1;
	assign hit     = (paddr == mfd_pkg::OFF_WORD) || (paddr == mfd_pkg::OFF_ADDR) ||
	                 (paddr == mfd_pkg::OFF_MACRO) || (paddr == mfd_pkg::OFF_KIND) ||
	                 (paddr == mfd_pkg::OFF_MISC) || (paddr == mfd_pkg::OFF_TGT) ||
	                 (paddr == mfd_pkg::OFF_PATH);
	assign pslverr = psel && penable && !hit;

	// Microword under decode.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			word_q <= mfd_pkg::RST_WORD;
		end else if (wr_en && paddr == mfd_pkg::OFF_WORD) begin
			word_q <= (word_q & ~wmask) | (pwdata & wmask);
		end
	end

	// Control-store address of the word, used for short branch blocks.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_q <= mfd_pkg::RST_ADDR;
		end else if (wr_en && paddr == mfd_pkg::OFF_ADDR) begin
			addr_q <= (addr_q & ~wmask[13:0]) | (pwdata[13:0] & wmask[13:0]);
		end
	end

	// Macro word register image; only its low bits reach the decode.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			macro_q <= mfd_pkg::RST_MACRO;
		end else if (wr_en && paddr == mfd_pkg::OFF_MACRO) begin
			macro_q <= (macro_q & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
		end
	end

	mfd_field_split u_split (
		.word      (word_q),
		.cur_addr  (addr_q),
		.macro_low (macro_q[3:0]),
		.kind      (kind_c),
		.special   (special_c),
		.alt_sel   (alt_c),
		.first_operand_bus_select_lit  (lit_c),
		.first_operand_bus_select_reg  (areg_c),
		.lit_val   (litv_c),
		.misc_a    (misca_c),
		.misc_red  (mred_c),
		.misc_aux  (maux_c),
		.cond      (cond_c),
		.target    (tgt_c),
		.tgt_valid (tgtv_c),
		.alu       (alu_c),
		.second_operand_bus_select      (second_operand_bus_select_c),
		.result_destination_field      (result_destination_field_c)
	);

	// Decode results are registered so a read never sees a half-settled word.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			kind_q    <= mfd_pkg::MFD_KIND_NONE;
			special_q <= 1'b0;
			lit_q     <= 1'b0;
			tgtv_q    <= 1'b0;
			alt_q     <= 5'h00;
			areg_q    <= 5'h00;
			misca_q   <= 5'h00;
			second_operand_bus_select_q    <= 5'h00;
			result_destination_field_q    <= 5'h00;
			litv_q    <= 16'h0000;
			mred_q    <= 4'h0;
			maux_q    <= 4'h0;
			cond_q    <= 4'h0;
			alu_q     <= 4'h0;
			tgt_q     <= 14'h0000;
		end else begin
			kind_q    <= kind_c;
			special_q <= special_c;
			lit_q     <= lit_c;
			tgtv_q    <= tgtv_c;
			alt_q     <= alt_c;
			areg_q    <= areg_c;
			misca_q   <= misca_c;
			second_operand_bus_select_q    <= second_operand_bus_select_c;
			result_destination_field_q    <= result_destination_field_c;
			litv_q    <= litv_c;
			mred_q    <= mred_c;
			maux_q    <= maux_c;
			cond_q    <= cond_c;
			alu_q     <= alu_c;
			tgt_q     <= tgt_c;
		end
	end

	assign dec_kind    = kind_q;
	assign dec_special = special_q;
	assign dec_lit     = lit_q;
	assign dec_target  = tgt_q;

	// Read mux over flops only; unmapped offsets read zero.
	always_comb begin
		prdata = 32'h0000_0000;
		case (paddr)
			mfd_pkg::OFF_WORD:  prdata = word_q;
			mfd_pkg::OFF_ADDR:  prdata = {18'h00000, addr_q};
			mfd_pkg::OFF_MACRO: prdata = {16'h0000, macro_q};
			mfd_pkg::OFF_KIND:  prdata = {17'h00000, areg_q, lit_q, alt_q, special_q, kind_q};
			mfd_pkg::OFF_MISC:  prdata = {14'h0000, cond_q, maux_q, mred_q, misca_q, 1'b0};
			mfd_pkg::OFF_TGT:   prdata = {15'h0000, tgtv_q, 2'b00, tgt_q};
			mfd_pkg::OFF_PATH:  prdata = {2'b00, result_destination_field_q, second_operand_bus_select_q, alu_q, litv_q};
			default:            prdata = 32'h0000_0000;
		endcase
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_short_end;
		(word_q[31:28] > mfd_pkg::OP_T2_MAX) && (word_q[31:28] <= mfd_pkg::OP_T4_MAX) &&
		(addr_q[5:0] == mfd_pkg::BLOCK_END);
	endsequence

	sequence s_long_special;
		(word_q[31:28] > mfd_pkg::OP_T4_MAX) && (word_q[31:28] <= mfd_pkg::OP_T5_MAX) &&
		(word_q[13:10] == mfd_pkg::ALU_ALTERNATE_ALU_MARKER_CODE);
	endsequence

	// The release edge still leaves the decode registers in reset, so start one edge later.
	property p_kind_range;
		presetn |=> (kind_q >= 3'b001) && (kind_q <= 3'b110);
	endproperty
	a_kind_range: assert property (p_kind_range) else $error("Kind out of range.");

	property p_kind_from_op;
		presetn && (word_q[31:28] <= mfd_pkg::OP_T1_MAX) |=> (kind_q == 3'b001);
	endproperty
	a_kind_from_op: assert property (p_kind_from_op) else $error("Selector decode wrong.");

	property p_special;
		presetn && (word_q[31:28] <= mfd_pkg::OP_T5_MAX && word_q[13:10] == mfd_pkg::ALU_ALTERNATE_ALU_MARKER_CODE)
			|=> special_q;
	endproperty
	a_special: assert property (p_special) else $error("Special kind missed.");

	property p_alt_sel_short;
		(special_q && (kind_q == 3'b011 || kind_q == 3'b100))
			|-> (alt_q == {1'b0, $past(word_q[21:18])});
	endproperty
	a_alt_sel_short: assert property (p_alt_sel_short) else $error("Alt selector wrong.");

	property p_one_use;
		!special_q |-> (alt_q == 5'h00);
	endproperty
	a_one_use: assert property (p_one_use) else $error("Field used twice.");

	property p_literal;
		presetn && (word_q[31:28] == 4'hf)
			|=> (litv_q == {2'b00, $past(word_q[27:14])}) && !special_q;
	endproperty
	a_literal: assert property (p_literal) else $error("Literal wrong.");

	property p_acc_default;
		(kind_q >= 3'b011 && kind_q <= 3'b101) |-> (areg_q == mfd_pkg::ACC_REG) && !lit_q;
	endproperty
	a_acc_default: assert property (p_acc_default) else $error("First bus not total.");

	property p_block_end;
		presetn ##0 s_short_end |=> (tgt_q[13:6] == $past(addr_q[13:6]) + 8'h01) && tgtv_q;
	endproperty
	a_block_end: assert property (p_block_end) else $error("Block wrap wrong.");

	property p_jump_modify;
		presetn ##0 s_long_special |=> (tgt_q == {$past(word_q[27:18]), $past(macro_q[3:0])});
	endproperty
	a_jump_modify: assert property (p_jump_modify) else $error("Jump modify wrong.");

	property p_lit_bus;
		presetn && (word_q[31:28] == 4'hf) |=> lit_q && (areg_q == 5'h00);
	endproperty
	a_lit_bus: assert property (p_lit_bus) else $error("Literal not on bus.");

	property p_layout;
		presetn |=> (result_destination_field_q == $past(word_q[4:0])) && (alu_q == $past(word_q[13:10])) &&
		(second_operand_bus_select_q == $past(word_q[9:5]));
	endproperty
	a_layout: assert property (p_layout) else $error("Field layout wrong.");

endmodule

//--- hw/mfd_pkg.sv
// Constants, register map and field layout of the microword format decoder.
// Assumes a 32-bit microword and a 14-bit control-store address.
package mfd_pkg;

	// Register byte offsets on the APB bus.
	localparam logic [7:0] OFF_WORD  = 8'h00;
	localparam logic [7:0] OFF_ADDR  = 8'h04;
	localparam logic [7:0] OFF_MACRO = 8'h08;
	localparam logic [7:0] OFF_KIND  = 8'h0c;
	localparam logic [7:0] OFF_MISC  = 8'h10;
	localparam logic [7:0] OFF_TGT   = 8'h14;
	localparam logic [7:0] OFF_PATH  = 8'h18;

	// Values after reset.
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;
	localparam logic [13:0] RST_ADDR  = 14'h0000;
	localparam logic [15:0] RST_MACRO = 16'h0000;

	// Field positions inside the microword (least significant bit of each).
	localparam int unsigned OP_LSB   = 28;
	localparam int unsigned A_LSB    = 23;
	localparam int unsigned SB_LSB   = 22;
	localparam int unsigned SP_LSB   = 18;
	localparam int unsigned SP2_LSB  = 14;
	localparam int unsigned LONG_LSB = 14;
	localparam int unsigned ALU_LSB  = 10;
	localparam int unsigned BB_LSB   = 5;
	localparam int unsigned ST_LSB   = 0;

	// Special codes and fixed selections.
	localparam logic [3:0] ALU_ALTERNATE_ALU_MARKER_CODE = 4'hf;
	localparam logic [4:0] ACC_REG       = 5'h04;
	localparam logic [5:0] BLOCK_END     = 6'h3f;

	// Highest selector value of each word kind; kind 6 takes the rest.
	localparam logic [3:0] OP_T1_MAX = 4'h2;
	localparam logic [3:0] OP_T2_MAX = 4'h6;
	localparam logic [3:0] OP_T3_MAX = 4'ha;
	localparam logic [3:0] OP_T4_MAX = 4'hc;
	localparam logic [3:0] OP_T5_MAX = 4'he;

	typedef enum logic [2:0] {
		MFD_KIND_NONE = 3'b000,
		MFD_KIND_1    = 3'b001,
		MFD_KIND_2    = 3'b010,
		MFD_KIND_3    = 3'b011,
		MFD_KIND_4    = 3'b100,
		MFD_KIND_5    = 3'b101,
		MFD_KIND_6    = 3'b110
	} mfd_kind_t;

endpackage

//--- hw/mfd_field_split.sv
// Combinational splitter of one microword into its decoded fields.
// Assumes the caller registers the results; no clock is used here.
`timescale 1ns/1ps
module mfd_field_split (
	input  wire logic [31:0]      word,         // Microword to decode.
	input  wire logic [13:0]      cur_addr,     // Address the word sits at.
	input  wire logic [3:0]       macro_low,    // Low bits of macro word register.
	output mfd_pkg::mfd_kind_t    kind,         // Decoded word kind.
	output logic                  special,      // Alternate ALU marker seen in kinds 1 to 5.
	output logic [4:0]            alt_sel,      // Alternate operation selector.
	output logic                  first_operand_bus_select_lit,     // First bus takes the literal.
	output logic [4:0]            first_operand_bus_select_reg,     // First bus register select.
	output logic [15:0]           lit_val,      // Literal value field.
	output logic [4:0]            misc_a,       // Shift or misc field a.
	output logic [3:0]            misc_red,     // Reduced misc field.
	output logic [3:0]            misc_aux,     // Auxiliary misc field.
	output logic [3:0]            cond,         // Condition select field.
	output logic [13:0]           target,       // Branch target.
	output logic                  tgt_valid,    // Target is meaningful.
	output logic [3:0]            alu,          // ALU code.
	output logic [4:0]            second_operand_bus_select,         // Second operand bus select.
	output logic [4:0]            result_destination_field          // Result destination field.
);

	// Kind from the selector alone; ALU, second bus and destination are read for every kind, the rest by kind.
	always_comb begin
		logic [3:0] op;
		logic [7:0] blk;
		op        = word[mfd_pkg::OP_LSB +: 4];
		blk       = cur_addr[13:6];
		kind      = mfd_pkg::MFD_KIND_6;
		if (op <= mfd_pkg::OP_T1_MAX) begin
			kind = mfd_pkg::MFD_KIND_1;
		end else if (op <= mfd_pkg::OP_T2_MAX) begin
			kind = mfd_pkg::MFD_KIND_2;
		end else if (op <= mfd_pkg::OP_T3_MAX) begin
			kind = mfd_pkg::MFD_KIND_3;
		end else if (op <= mfd_pkg::OP_T4_MAX) begin
			kind = mfd_pkg::MFD_KIND_4;
		end else if (op <= mfd_pkg::OP_T5_MAX) begin
			kind = mfd_pkg::MFD_KIND_5;
		end
		alu       = word[mfd_pkg::ALU_LSB +: 4];
		second_operand_bus_select      = word[mfd_pkg::BB_LSB +: 5];
		result_destination_field      = word[mfd_pkg::ST_LSB +: 5];
		special   = (kind != mfd_pkg::MFD_KIND_6) && (alu == mfd_pkg::ALU_ALTERNATE_ALU_MARKER_CODE);
		alt_sel   = 5'h00;
		first_operand_bus_select_lit  = 1'b0;
		first_operand_bus_select_reg  = mfd_pkg::ACC_REG;
		lit_val   = 16'h0000;
		misc_a    = 5'h00;
		misc_red  = 4'h0;
		misc_aux  = 4'h0;
		cond      = 4'h0;
		target    = 14'h0000;
		tgt_valid = 1'b0;
		// One field value drives one micro-operation; unused fields read zero.
		case (kind)
			mfd_pkg::MFD_KIND_1, mfd_pkg::MFD_KIND_2: begin
				first_operand_bus_select_reg = word[mfd_pkg::A_LSB +: 5];
				if (special) begin
					alt_sel = word[mfd_pkg::SP_LSB +: 5];
				end else begin
					misc_a = word[mfd_pkg::SP_LSB +: 5];
				end
				if (kind == mfd_pkg::MFD_KIND_1) begin
					misc_aux = word[mfd_pkg::SP2_LSB +: 4];
				end else begin
					cond = word[mfd_pkg::SP2_LSB +: 4];
				end
			end
			mfd_pkg::MFD_KIND_3, mfd_pkg::MFD_KIND_4: begin
				if (special) begin
					alt_sel = {1'b0, word[mfd_pkg::SP_LSB +: 4]};
				end else begin
					misc_red = word[mfd_pkg::SP_LSB +: 4];
				end
				if (kind == mfd_pkg::MFD_KIND_3) begin
					cond = word[mfd_pkg::SP2_LSB +: 4];
				end else begin
					misc_aux = word[mfd_pkg::SP2_LSB +: 4];
				end
				// The last word of a block branches into the next block.
				if (cur_addr[5:0] == mfd_pkg::BLOCK_END) begin
					blk = blk + 8'h01;
				end
				target    = {blk, word[mfd_pkg::SB_LSB +: 6]};
				tgt_valid = 1'b1;
			end
			mfd_pkg::MFD_KIND_5: begin
				target = word[mfd_pkg::LONG_LSB +: 14];
				if (special) begin
					target[3:0] = macro_low;
				end
				tgt_valid = 1'b1;
			end
			default: begin
				lit_val  = {2'b00, word[mfd_pkg::LONG_LSB +: 14]};
				first_operand_bus_select_lit = 1'b1;
				first_operand_bus_select_reg = 5'h00;
			end
		endcase
	end

endmodule

//--- bench/mfd_ctrl_store.sv
// Control-store model that hands microwords to the bench, one word per address.
// Assumes the bench loads a location before it fetches it.
`timescale 1ns/1ps
module mfd_ctrl_store (
	input  wire logic        pclk, // Processor clock.
	input  wire logic [13:0] addr, // Control-store address.
	output logic      [31:0] word  // Word at addr, one edge later.
);
	logic [31:0] mem [0:63];
	logic [63:0] loaded;

	// Only 64 locations are kept; upper address bits alias, which is enough for the bench.
	task automatic store(input logic [13:0] a, input logic [31:0] w);
		mem[a[5:0]] = w;
		loaded[a[5:0]] = 1'b1;
	endtask

	// Start empty, with a moving pattern so a stale word never looks valid.
	initial begin
		loaded = '0;
		word = 32'h5a5a_a5a5;
	end

	// Registered read; an unloaded location returns a pattern that changes every cycle.
	always @(posedge pclk) begin
		if (loaded[addr[5:0]] === 1'b1) begin
			word <= mem[addr[5:0]];
		end else begin
			word <= {word[30:0], ~word[31]};
		end
	end
endmodule

//--- bench/testbench.sv
// Self-checking bench for the microword format decoder over its APB port.
// Assumes zero wait states and a decode that lands one edge after a write.
`timescale 1ns/1ps
module testbench;
	typedef struct {logic [31:0] d; logic [31:0] m; logic e;} mfd_note_t;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [2:0]  dec_kind;
	logic        dec_special;
	logic        dec_lit;
	logic [13:0] dec_target;
	logic [13:0] cs_addr;
	logic [31:0] cs_word;
	logic [31:0] seed;
	int          err_count;
	int          checks;
	mfd_note_t   notes[$];
	mfd_note_t   nt;

	mfd_microword_decoder #(.WORD_W(32)) mfd_microword_decoder_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dec_kind(dec_kind), .dec_special(dec_special),
		.dec_lit(dec_lit), .dec_target(dec_target));
	mfd_ctrl_store cs_i (.pclk(pclk), .addr(cs_addr), .word(cs_word));

	// Free-running 25 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// One APB transfer with an idle cycle after it; the note is judged by the monitor.
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
			input logic [31:0] x, input logic [31:0] m, input logic e);
		int n;
		notes.push_back('{x, m, e});
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			err_count++;
			final_report();
		end else begin
			psel    <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask

	// Fetch a word through the control store, load it and compare every decoded view.
	task automatic decode_chk(input logic [31:0] w, input logic [13:0] a, input logic [15:0] m);
		logic [3:0]  s;
		logic [2:0]  k;
		logic        sp;
		logic [4:0]  ab;
		logic [13:0] t;
		logic [7:0]  blk;
		logic [4:0]  al;
		logic [4:0]  ma;
		logic [3:0]  mr;
		logic [3:0]  cd;
		logic [3:0]  mx;
		s = w[31:28];
		k = (s <= mfd_pkg::OP_T1_MAX) ? 3'h1 : (s <= mfd_pkg::OP_T2_MAX) ? 3'h2 :
			(s <= mfd_pkg::OP_T3_MAX) ? 3'h3 : (s <= mfd_pkg::OP_T4_MAX) ? 3'h4 :
			(s <= mfd_pkg::OP_T5_MAX) ? 3'h5 : 3'h6;
		sp = (k != 3'h6) && (w[13:10] == mfd_pkg::ALU_ALTERNATE_ALU_MARKER_CODE);
		ab = (k <= 3'h2) ? w[27:23] : (k <= 3'h5) ? mfd_pkg::ACC_REG : 5'h00;
		// Unused fields of a kind must read zero, so every bit is compared.
		al = !sp ? 5'h00 : (k <= 3'h2) ? w[22:18] : (k <= 3'h4) ? {1'b0, w[21:18]} : 5'h00;
		ma = (k <= 3'h2 && !sp) ? w[22:18] : 5'h00;
		mr = ((k == 3'h3 || k == 3'h4) && !sp) ? w[21:18] : 4'h0;
		cd = (k == 3'h2 || k == 3'h3) ? w[17:14] : 4'h0;
		mx = (k == 3'h1 || k == 3'h4) ? w[17:14] : 4'h0;
		blk = a[13:6] + {7'h00, a[5:0] == mfd_pkg::BLOCK_END};
		t = (k == 3'h3 || k == 3'h4) ? {blk, w[27:22]} :
			(k == 3'h5) ? (sp ? {w[27:18], m[3:0]} : w[27:14]) : 14'h0000;
		cs_i.store(a, w);
		cs_addr <= a;
		@(posedge pclk);
		@(posedge pclk);
		xfer(1'b1, mfd_pkg::OFF_WORD, cs_word, 32'h0, 32'h0, 1'b0);
		xfer(1'b1, mfd_pkg::OFF_ADDR, {18'h0, a}, 32'h0, 32'h0, 1'b0);
		xfer(1'b1, mfd_pkg::OFF_MACRO, {16'h0, m}, 32'h0, 32'h0, 1'b0);
		xfer(1'b0, mfd_pkg::OFF_KIND, 32'h0,
			{17'h0, ab, k == 3'h6, al, sp, k},
			32'hffffffff, 1'b0);
		xfer(1'b0, mfd_pkg::OFF_TGT, 32'h0, {15'h0, k >= 3'h3 && k <= 3'h5, 2'h0, t},
			32'hffffffff, 1'b0);
		xfer(1'b0, mfd_pkg::OFF_PATH, 32'h0,
			{2'h0, w[4:0], w[9:5], w[13:10], (k == 3'h6) ? {2'h0, w[27:14]} : 16'h0},
			32'hffffffff, 1'b0);
		xfer(1'b0, mfd_pkg::OFF_MISC, 32'h0, {14'h0, cd, mx, mr, ma, 1'b0},
			32'hffffffff, 1'b0);
		check("dec_kind", {29'h0, dec_kind}, {29'h0, k});
		check("dec_special", {31'h0, dec_special}, {31'h0, sp});
		check("dec_lit", {31'h0, dec_lit}, {31'h0, k == 3'h6});
		check("dec_target", {18'h0, dec_target}, {18'h0, t});
	endtask

	// Monitor: every completed access takes the oldest note and is judged against it.
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			if (notes.size() == 0) begin
				check("note queue", 32'h1, 32'h0);
			end else begin
				nt = notes.pop_front();
				check("prdata", prdata & nt.m, nt.d & nt.m);
				check("pslverr", {31'h0, pslverr}, {31'h0, nt.e});
			end
		end
	end

	// Main sequence: reset values, every selector plain and special, boundaries, refusals.
	initial begin
		logic [31:0] w;
		logic [31:0] r;
		seed = 32'h0000_6565;
		err_count = 0;
		checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hf;
		cs_addr = 14'h0000;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		xfer(1'b0, mfd_pkg::OFF_WORD, 32'h0, mfd_pkg::RST_WORD, 32'hffffffff, 1'b0);
		xfer(1'b0, mfd_pkg::OFF_ADDR, 32'h0, {18'h0, mfd_pkg::RST_ADDR}, 32'h3fff, 1'b0);
		xfer(1'b0, mfd_pkg::OFF_MACRO, 32'h0, {16'h0, mfd_pkg::RST_MACRO}, 32'hffff, 1'b0);
		xfer(1'b0, mfd_pkg::OFF_KIND, 32'h0, 32'h1, 32'h7e0f, 1'b0);
		for (int s = 0; s < 32; s++) begin
			w = rnd();
			r = rnd();
			w[31:28] = s[3:0];
			w[13:10] = s[4] ? mfd_pkg::ALU_ALTERNATE_ALU_MARKER_CODE : {1'b0, w[12:10]};
			decode_chk(w, r[13:0], r[31:16]);
		end
		decode_chk(32'h7fc0_0123, 14'h00bf, 16'h0000);
		decode_chk(32'hb000_3c00, 14'h3fff, 16'h0000);
		decode_chk(32'h7555_0000, 14'h0040, 16'h0000);
		decode_chk(32'hd123_3c00, 14'h0100, 16'h09a5);
		decode_chk(32'hfedc_bfff, 14'h0000, 16'h0000);
		// Refusals: unmapped, misaligned and read-only places.
		xfer(1'b0, 8'h1c, 32'h0, 32'h0, 32'hffffffff, 1'b1);
		xfer(1'b1, 8'h20, 32'h1234, 32'h0, 32'h0, 1'b1);
		xfer(1'b0, 8'h01, 32'h0, 32'h0, 32'hffffffff, 1'b1);
		xfer(1'b1, mfd_pkg::OFF_KIND, 32'hffffffff, 32'h0, 32'h0, 1'b0);
		xfer(1'b0, mfd_pkg::OFF_KIND, 32'h0, 32'h206, 32'h7e0f, 1'b0);
		// Byte strobes: only the low lane of the word may change.
		xfer(1'b1, mfd_pkg::OFF_WORD, 32'h0, 32'h0, 32'h0, 1'b0);
		pstrb <= 4'h1;
		xfer(1'b1, mfd_pkg::OFF_WORD, 32'hffffffff, 32'h0, 32'h0, 1'b0);
		pstrb <= 4'hf;
		xfer(1'b0, mfd_pkg::OFF_WORD, 32'h0, 32'h000000ff, 32'hffffffff, 1'b0);
		// A second reset in mid-run must clear the word again.
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		xfer(1'b0, mfd_pkg::OFF_WORD, 32'h0, 32'h0, 32'hffffffff, 1'b0);
		check("dec_kind", {29'h0, dec_kind}, 32'h1);
		@(posedge pclk);
		final_report();
	end
endmodule
